// *** crf_params.svh ***
// Purpose: constants for the receiver flag and status block
// Assumes: 32-bit classic Wishbone, word-aligned registers
// Notes: offsets are byte addresses
//
// Summary of operation
// - Write one clears flag, zero ignored
// - State fields are read-only
// - Flags held at reset during init mode
// - State fields track counters despite init mode
// - Wake flag sets on sleep activity when enabled
// - Wake request while wake flag enabled
// - Status-change flag sets on bus state change
// - State fields frozen while status-change pending
// - Error request from enabled status-change or overrun
// - Receiver code from receive count, bus-off copy
// - Transmitter code from transmit count
// - Leaving bus-off returns receiver code to the receive count
// - Receiver bus-off only when transmit count exceeds 255
// - Overrun flag sets on overrun
// - Receive-full sets on accepted message shift-in
// - No shift while receive-full set
// - Receive request while receive-full enabled
// - Clear only when setting condition gone
// - Each flag gated by own enable bit
`ifndef CRF_PARAMS_SVH
`define CRF_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CRF_ADDR_FLAGS 8'h00
`define CRF_ADDR_IRQEN 8'h04
`define CRF_ADDR_CTRL 8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CRF_BIT_WAKE 7
`define CRF_BIT_CSC 6
`define CRF_BIT_OVR 1
`define CRF_BIT_RXF 0
`define CRF_BIT_WAKE_EN 0

// ----------------------------------------
// Reset values and thresholds
// ----------------------------------------
`define CRF_FLAGS_RST 8'h00
`define CRF_IRQEN_RST 8'h00
`define CRF_WARN_LIMIT 9'h060
`define CRF_ERR_LIMIT 9'h07F
`define CRF_BUSOFF_LIMIT 9'h0FF

`endif

// *** crf_pkg.sv ***
// Purpose: types for the receiver flag and status block
// Assumes: nothing
// Notes: none
package crf_pkg;

	typedef enum logic [1:0] {
		CRF_ST_OK = 2'h0,
		CRF_ST_WARN = 2'h1,
		CRF_ST_ERR = 2'h2,
		CRF_ST_BUSOFF = 2'h3
	} crf_state_t;

	typedef struct packed {
		logic [8:0] tx_count;
		logic [8:0] rx_count;
		logic overrun;
		logic accepted;
		logic sleep_activity;
		logic sleeping;
	} crf_engine_t;

	typedef struct packed {
		logic [7:0] addr;
		logic we;
		logic [3:0] sel;
		logic [31:0] data;
	} crf_wb_req_t;

endpackage

// *** crf_state_enc.sv ***
// Purpose: error counters to state codes
// Assumes: counters saturate at 9 bits
// Notes: purely combinational
`timescale 1ns/100ps
`include "crf_params.svh"
module crf_state_enc
(
	// Counters
	input wire logic [8:0] tx_count_i,
	input wire logic [8:0] rx_count_i,
	// Codes
	output crf_pkg::crf_state_t tx_state_o,
	output crf_pkg::crf_state_t rx_state_o
);

	always_comb
	begin
		if (tx_count_i > `CRF_BUSOFF_LIMIT)
			tx_state_o = crf_pkg::CRF_ST_BUSOFF;
		else if (tx_count_i > `CRF_ERR_LIMIT)
			tx_state_o = crf_pkg::CRF_ST_ERR;
		else if (tx_count_i > `CRF_WARN_LIMIT)
			tx_state_o = crf_pkg::CRF_ST_WARN;
		else
			tx_state_o = crf_pkg::CRF_ST_OK;
	end

	always_comb
	begin
		// Bus-off copy wins over the receive count
		if (tx_count_i > `CRF_BUSOFF_LIMIT)
			rx_state_o = crf_pkg::CRF_ST_BUSOFF;
		else if (rx_count_i > `CRF_ERR_LIMIT)
			rx_state_o = crf_pkg::CRF_ST_ERR;
		else if (rx_count_i > `CRF_WARN_LIMIT)
			rx_state_o = crf_pkg::CRF_ST_WARN;
		else
			rx_state_o = crf_pkg::CRF_ST_OK;
	end

endmodule

// *** crf_w1c_flag.sv ***
// Purpose: one sticky flag, write-one-to-clear
// Assumes: set input is a one-cycle event or a level
// Notes: set beats clear in the same cycle
`timescale 1ns/100ps
module crf_w1c_flag
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic hold_i,
	input wire logic set_i,
	input wire logic clr_i,
	// State
	output logic flag_o
);

	always_ff @(posedge clk_i)
	begin
		if (rst_i || hold_i)
			flag_o <= 1'b0;
		else if (set_i)
			flag_o <= 1'b1;
		else if (clr_i)
			flag_o <= 1'b0;
	end

endmodule

// *** crf_top.sv ***
// Purpose: receiver flags, bus state codes and requests of a CAN controller
// Assumes: engine inputs are synchronous to clk_i
// Notes: 20 MHz clock; Wishbone classic slave, one wait state
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/100ps
`include "crf_params.svh"
module crf_top
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Controller mode
	input wire logic init_request_i,
	input wire logic init_acknowledge_i,
	// Protocol engine
	input wire crf_pkg::crf_engine_t engine_i,
	output logic shift_allow_o,
	// Requests
	output logic wake_irq_o,
	output logic error_irq_o,
	output logic receive_irq_o
);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic bus_req;
	logic wr_flags;
	logic wr_irqen;
	logic wr_ctrl;
	logic init_mode;
	logic out_of_init;
	logic [7:0] flags_rd;
	logic [7:0] irqen_q;
	logic wake_enable_q;
	logic [31:0] rd_d;

	assign bus_req = cyc_i && stb_i && !ack_o;
	assign init_mode = init_request_i && init_acknowledge_i;
	assign out_of_init = !init_request_i && !init_acknowledge_i;
	assign wr_flags = bus_req && we_i && sel_i[0] && adr_i == `CRF_ADDR_FLAGS && out_of_init;
	assign wr_irqen = bus_req && we_i && sel_i[0] && adr_i == `CRF_ADDR_IRQEN && out_of_init;
	assign wr_ctrl = bus_req && we_i && sel_i[0] && adr_i == `CRF_ADDR_CTRL;

	// ----------------------------------------
	// State codes
	// ----------------------------------------
	crf_pkg::crf_state_t tx_now;
	crf_pkg::crf_state_t rx_now;
	crf_pkg::crf_state_t tx_q;
	crf_pkg::crf_state_t rx_q;
	crf_pkg::crf_state_t tx_prev_q;
	crf_pkg::crf_state_t rx_prev_q;
	logic change;
	logic wake_q;
	logic csc_q;
	logic ovr_q;
	logic rxf_q;

	crf_state_enc u_enc
	(
		.tx_count_i(engine_i.tx_count),
		.rx_count_i(engine_i.rx_count),
		.tx_state_o(tx_now),
		.rx_state_o(rx_now)
	);

	// On bus-off exit the shared encoder takes the receiver code from the receive count again
	assign change = (tx_now != tx_prev_q) || (rx_now != rx_prev_q);

	// Not reset by init mode, only by rst_i
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_prev_q <= crf_pkg::CRF_ST_OK;
			rx_prev_q <= crf_pkg::CRF_ST_OK;
		end
		else
		begin
			tx_prev_q <= tx_now;
			rx_prev_q <= rx_now;
		end
	end

	// Visible fields; frozen while change pending, never written
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_q <= crf_pkg::CRF_ST_OK;
			rx_q <= crf_pkg::CRF_ST_OK;
		end
		else if (!csc_q)
		begin
			tx_q <= tx_now;
			rx_q <= rx_now;
		end
	end

	// ----------------------------------------
	// Flags
	// ----------------------------------------
	// Sleep activity only counts with wake enable
	crf_w1c_flag u_wake
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.hold_i(init_mode),
		.set_i(engine_i.sleeping && engine_i.sleep_activity && wake_enable_q),
		.clr_i(wr_flags && dat_i[`CRF_BIT_WAKE]),
		.flag_o(wake_q)
	);

	crf_w1c_flag u_csc
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.hold_i(init_mode),
		.set_i(change),
		.clr_i(wr_flags && dat_i[`CRF_BIT_CSC]),
		.flag_o(csc_q)
	);

	crf_w1c_flag u_ovr
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.hold_i(init_mode),
		.set_i(engine_i.overrun),
		.clr_i(wr_flags && dat_i[`CRF_BIT_OVR]),
		.flag_o(ovr_q)
	);

	// Shift-in only accepted while buffer free
	crf_w1c_flag u_rxf
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.hold_i(init_mode),
		.set_i(engine_i.accepted && shift_allow_o),
		.clr_i(wr_flags && dat_i[`CRF_BIT_RXF]),
		.flag_o(rxf_q)
	);

	// ----------------------------------------
	// Enables
	// ----------------------------------------
	// Enable register is also held in init mode
	always_ff @(posedge clk_i)
	begin
		if (rst_i || init_mode)
			irqen_q <= `CRF_IRQEN_RST;
		else if (wr_irqen)
			irqen_q <= dat_i[7:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wake_enable_q <= 1'b0;
		else if (wr_ctrl)
			wake_enable_q <= dat_i[`CRF_BIT_WAKE_EN];
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Requests follow flags one cycle late, registered
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wake_irq_o <= 1'b0;
			error_irq_o <= 1'b0;
			receive_irq_o <= 1'b0;
			shift_allow_o <= 1'b1;
		end
		else
		begin
			wake_irq_o <= wake_q && irqen_q[`CRF_BIT_WAKE];
			error_irq_o <= (csc_q && irqen_q[`CRF_BIT_CSC]) || (ovr_q && irqen_q[`CRF_BIT_OVR]);
			receive_irq_o <= rxf_q && irqen_q[`CRF_BIT_RXF];
			// Blocks the next shift as soon as rxf is set or being set
			shift_allow_o <= !(rxf_q || (engine_i.accepted && shift_allow_o)) ||
				(wr_flags && dat_i[`CRF_BIT_RXF] && !(engine_i.accepted && shift_allow_o));
		end
	end

	assign flags_rd = {wake_q, csc_q, rx_q, tx_q, ovr_q, rxf_q};

	// Reads have no side effects
	always_comb
	begin
		rd_d = 32'h0000_0000;
		if (adr_i == `CRF_ADDR_FLAGS)
			rd_d = {24'h00_0000, flags_rd};
		else if (adr_i == `CRF_ADDR_IRQEN)
			rd_d = {24'h00_0000, irqen_q};
		else if (adr_i == `CRF_ADDR_CTRL)
			rd_d = {31'h0000_0000, wake_enable_q};
	end

	// Unmapped addresses ack with zero data
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= bus_req;
			dat_o <= rd_d;
		end
	end

endmodule

// *** crf_props.sv ***
// Purpose: port checks of crf_top
// Assumes: bus released after each ack
// Notes: flags seen via reads only
`timescale 1ns/100ps
module crf_props
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic init_request_i,
	input wire logic init_acknowledge_i,
	input wire crf_pkg::crf_engine_t engine_i,
	input wire logic shift_allow_o,
	input wire logic receive_irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	ack_once_a: assert property (ack_o |=> !ack_o) else $error("long ack");
	init_hold_a: assert property ((init_request_i && init_acknowledge_i) [*3] |-> !receive_irq_o)
		else $error("irq in init");
	shift_stop_a: assert property (engine_i.accepted && shift_allow_o && !init_request_i |=> !shift_allow_o)
		else $error("shift not stopped");
	shift_hold_a: assert property (!shift_allow_o && !(cyc_i && stb_i && we_i) && !init_request_i
		&& !$past(init_request_i) |=> !shift_allow_o) else $error("shift reopened");
	rx_irq_a: assert property (receive_irq_o |-> !$past(shift_allow_o)) else $error("stray rx irq");
	unmapped_a: assert property (ack_o && !we_i && adr_i == 8'h10 |-> dat_o == 32'h0) else $error("bad read");
	busoff_a: assert property (ack_o && !we_i && adr_i == 8'h00 && dat_o[5:4] == 2'h3 |-> dat_o[3:2] == 2'h3)
		else $error("rx bus-off alone");
endmodule
bind crf_top crf_props chk_u (.*);

// *** crf_eng_model.sv ***
// Purpose: protocol engine stand-in for crf_top
// Assumes: bench commands arrivals and counts
// Notes: one waiting message; a further one overruns
`timescale 1ns/100ps
module crf_eng_model
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic msg_i,
	input wire logic act_i,
	input wire logic sleep_i,
	input wire logic [8:0] tx_i,
	input wire logic [8:0] rx_i,
	input wire logic shift_allow_i,
	output crf_pkg::crf_engine_t eng_o
);
	logic wait_q;
	always_ff @(posedge clk_i)
	begin
		eng_o.tx_count <= tx_i;
		eng_o.rx_count <= rx_i;
		eng_o.sleeping <= sleep_i;
		eng_o.sleep_activity <= act_i && sleep_i;
		eng_o.overrun <= !rst_i && msg_i && wait_q;
		// Waits for release; a message arriving meanwhile overruns
		eng_o.accepted <= !rst_i && !msg_i && wait_q && shift_allow_i && !eng_o.accepted;
		if (rst_i)
			wait_q <= 1'b0;
		else if (msg_i)
			wait_q <= 1'b1;
		else if (shift_allow_i && !eng_o.accepted)
			wait_q <= 1'b0;
	end
endmodule

// *** crf_top_tb_top.sv ***
// Purpose: self-checking bench of crf_top
// Assumes: engine stand-in crf_eng_model
// Notes: ef is the reference flag image
`timescale 1ns/100ps
module crf_top_tb_top;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sa, wi, ei, ri, iq, msg, act, slp;
	logic [3:0] sel_i, last;
	logic [7:0] adr_i, ef;
	logic [8:0] tx, rx;
	logic [31:0] dat_i, dat_o, rd, lf;
	crf_pkg::crf_engine_t eng;
	int fail_count, tests_run, cyc_n, i, t;
	int v[6] = '{96, 97, 127, 128, 255, 256};
	crf_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .init_request_i(iq), .init_acknowledge_i(iq),
		.engine_i(eng), .shift_allow_o(sa), .wake_irq_o(wi), .error_irq_o(ei), .receive_irq_o(ri));
	crf_eng_model eng_u (.clk_i(clk_i), .rst_i(rst_i), .msg_i(msg), .act_i(act), .sleep_i(slp), .tx_i(tx),
		.rx_i(rx), .shift_allow_i(sa), .eng_o(eng));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic print_verdict();
		if (fail_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("BAD %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, 24'h0, d, 4'h1};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 50);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'h0;
		if (n >= 50)
			fail_count++;
	endtask
	task automatic rdf();
		wb(8'h00, 1'b0, 8'h00);
		chk(rd, {24'h0, ef});
	endtask
	task automatic cnt(input int a, input int b);
		logic [3:0] e;
		e = {a > 255 ? 2'h3 : b > 127 ? 2'h2 : b > 96 ? 2'h1 : 2'h0, a > 255 ? 2'h3 : a > 127 ? 2'h2 : a > 96 ? 2'h1 : 2'h0};
		@(posedge clk_i);
		tx <= a[8:0];
		rx <= b[8:0];
		if (!ef[6])
			ef[5:2] = e;
		ef[6] = ef[6] | ((e != last) & !iq);
		last = e;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic clr(input logic [7:0] m);
		wb(8'h00, 1'b1, m);
		ef = ef & ~(m & 8'hC3);
		if (m[6])
			ef[5:2] = last;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic pulse(input logic k);
		@(posedge clk_i);
		{msg, act} <= {k, !k};
		@(posedge clk_i);
		{msg, act} <= 2'h0;
		repeat (4) @(posedge clk_i);
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc_n++;
		if (cyc_n > 20000)
		begin
			fail_count++;
			print_verdict();
		end
	end
	initial
	begin
		{rst_i, cyc_i, stb_i, we_i, iq, msg, act, slp} = 8'h80;
		{adr_i, sel_i, dat_i, tx, rx, ef, last} = '0;
		lf = 32'h11DBEBAD;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 20; i += 4)
		begin
			wb(i[7:0], 1'b0, 8'h00);
			chk(rd, 32'h0);
		end
		for (i = 0; i < 24; i++)
		begin
			lf = nx(lf);
			t = v[lf[2:0] % 6];
			cnt(t, last[1:0] == 2'h3 && t < 256 ? 0 : v[lf[6:4] % 6]);
			rdf();
			if (i % 3 == 2)
				clr(8'h40);
		end
		clr(8'h40);
		wb(8'h04, 1'b1, 8'h43);
		slp <= 1'b1;
		for (i = 0; i < 2; i++)
		begin
			wb(8'h08, 1'b1, i[7:0]);
			pulse(1'b0);
			ef[7] = i[0];
			rdf();
		end
		chk(wi, 1'b0);
		wb(8'h04, 1'b1, 8'hC3);
		repeat (2) @(posedge clk_i);
		chk(wi, 1'b1);
		clr(8'h80);
		chk(wi, 1'b0);
		pulse(1'b1);
		ef[0] = 1'b1;
		chk({ri, sa}, 2'h2);
		pulse(1'b1);
		pulse(1'b1);
		ef[1] = 1'b1;
		chk(ei, 1'b1);
		wb(8'h00, 1'b1, 8'h3C);
		rdf();
		clr(8'h03);
		ef[0] = 1'b1;
		repeat (2) @(posedge clk_i);
		rdf();
		clr(8'h01);
		chk(sa, 1'b1);
		pulse(1'b1);
		@(posedge clk_i);
		iq <= 1'b1;
		ef = ef & 8'h3C;
		cnt(300, 0);
		wb(8'h00, 1'b1, 8'hFF);
		rdf();
		chk({wi, ei, ri}, 3'h0);
		@(posedge clk_i);
		iq <= 1'b0;
		cnt(0, 0);
		rdf();
		print_verdict();
	end
endmodule
